//--- hw/sdcrm_pkg.sv
// Constants for the shadowed dual-channel register bank and its serial port.
package sdcrm_pkg;

	// ****************************************
	// Address map
	// ****************************************
	localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
	localparam logic [7:0] ADDR_CHIP_LAST = 8'h02;
	localparam logic [7:0] ADDR_CHAN_SEL = 8'h05;
	localparam logic [7:0] ADDR_FUNC_FIRST = 8'h08;
	localparam logic [7:0] ADDR_FUNC_LAST = 8'h25;
	localparam logic [7:0] ADDR_OPEN_HOLE = 8'h13;
	localparam logic [7:0] ADDR_OUT_FMT = 8'h14;
	localparam logic [7:0] ADDR_SHADOW_LO_LAST = 8'h20;
	localparam logic [7:0] ADDR_DIG_FIRST = 8'h3a;
	localparam logic [7:0] ADDR_DIG_LAST = 8'h59;
	localparam logic [7:0] ADDR_XFER = 8'hff;
	localparam logic [7:0] ADDR_LOCAL_FIRST = 8'h08;
	localparam logic [7:0] ADDR_LOCAL_LAST = 8'h25;

	// ****************************************
	// Field positions and command values
	// ****************************************
	localparam int BIT_LSB_FIRST = 6;
	localparam int BIT_CHAN_A = 0;
	localparam int BIT_CHAN_B = 1;
	localparam int BIT_XFER = 0;
	localparam logic [7:0] XFER_CMD = 8'h01;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_PORT_CFG = 8'h00;
	localparam logic [7:0] RST_CHAN_SEL = 8'h03;
	localparam logic [7:0] RST_OUT_FMT = 8'h05;
	localparam logic [7:0] RST_OTHER = 8'h00;

	// ****************************************
	// Serial framing
	// ****************************************
	localparam int INSTR_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int INSTR_RD_BIT = 15;
	localparam int INSTR_LEN_HI = 14;
	localparam int INSTR_LEN_LO = 13;
	localparam logic [1:0] LEN_STREAM = 2'b11;

endpackage : sdcrm_pkg

//--- hw/sdcrm_bus_if.sv
// Byte access path between the serial port and the register bank.
`timescale 1ns/1ps
interface sdcrm_bus_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wdata;
	logic [7:0] rd_addr;
	logic [7:0] rdata;
	logic lsb_first;

	modport port_side (
		output wr_en,
		output wr_addr,
		output wdata,
		output rd_addr,
		input rdata,
		input lsb_first
	);

	modport bank_side (
		input wr_en,
		input wr_addr,
		input wdata,
		input rd_addr,
		output rdata,
		output lsb_first
	);
endinterface : sdcrm_bus_if

//--- hw/sdcrm_serial.sv
// Three-wire serial port: pin synchronisers, instruction and byte framing.
`timescale 1ns/1ps
module sdcrm_serial (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic sclk_i,
	input wire logic csb_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	// Register bank
	sdcrm_bus_if.port_side bus
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [2:0] {
		ST_INSTR = 3'b001,
		ST_DATA = 3'b010,
		ST_DONE = 3'b100
	} sdcrm_ser_state_t;

	typedef struct packed {
		logic [1:0] sclk_sy;
		logic sclk_d;
		logic [1:0] csb_sy;
		logic [1:0] sdio_sy;
		sdcrm_ser_state_t state;
		logic [3:0] cnt;
		logic [15:0] sh;
		logic rd;
		logic [1:0] len;
		logic [1:0] nbytes;
		logic [7:0] addr;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wdata;
		logic dout;
		logic oe;
	} sdcrm_ser_t;

	sdcrm_ser_t s_r;
	sdcrm_ser_t s_nxt;

	// ****************************************
	// Framing
	// ****************************************
	always_comb
	begin
		logic rise;
		logic fall;
		logic din;
		logic lsb;
		logic [15:0] nsh;
		logic [2:0] idx;
		rise = 1'b0;
		fall = 1'b0;
		din = 1'b0;
		lsb = 1'b0;
		nsh = 16'h0000;
		idx = 3'h0;
		s_nxt = s_r;
		s_nxt.wr_en = 1'b0;
		// Only the second stage of each synchroniser is read below.
		s_nxt.sclk_sy = {s_r.sclk_sy[0], sclk_i};
		s_nxt.sclk_d = s_r.sclk_sy[1];
		s_nxt.csb_sy = {s_r.csb_sy[0], csb_n_i};
		s_nxt.sdio_sy = {s_r.sdio_sy[0], sdio_i};
		rise = s_r.sclk_sy[1] & ~s_r.sclk_d;
		fall = ~s_r.sclk_sy[1] & s_r.sclk_d;
		din = s_r.sdio_sy[1];
		lsb = bus.lsb_first;
		idx = s_r.cnt[2:0];
		if (s_r.csb_sy[1])
		begin
			s_nxt.state = ST_INSTR;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end
		else
		begin
			case (s_r.state)
				ST_INSTR:
				begin
					s_nxt.oe = 1'b0;
					if (rise)
					begin
						// Bit order follows the port configuration.
						nsh = lsb ? {din, s_r.sh[15:1]} : {s_r.sh[14:0], din};
						s_nxt.sh = nsh;
						s_nxt.cnt = s_r.cnt + 4'h1;
						if (s_r.cnt == 4'(sdcrm_pkg::INSTR_BITS - 1))
						begin
							s_nxt.state = ST_DATA;
							s_nxt.cnt = 4'h0;
							s_nxt.nbytes = 2'b00;
							s_nxt.rd = nsh[sdcrm_pkg::INSTR_RD_BIT];
							s_nxt.len = nsh[sdcrm_pkg::INSTR_LEN_HI:
								sdcrm_pkg::INSTR_LEN_LO];
							s_nxt.addr = nsh[7:0];
						end
					end
				end
				ST_DATA:
				begin
					if (fall && s_r.rd)
					begin
						s_nxt.dout = lsb ? bus.rdata[idx] : bus.rdata[3'h7 - idx];
						s_nxt.oe = 1'b1;
					end
					if (rise)
					begin
						nsh = s_r.sh;
						nsh[7:0] = lsb ? {din, s_r.sh[7:1]} : {s_r.sh[6:0], din};
						s_nxt.sh = nsh;
						s_nxt.cnt = s_r.cnt + 4'h1;
						if (s_r.cnt == 4'(sdcrm_pkg::BYTE_BITS - 1))
						begin
							s_nxt.cnt = 4'h0;
							s_nxt.wr_en = ~s_r.rd;
							s_nxt.wr_addr = s_r.addr;
							s_nxt.wdata = nsh[7:0];
							// Streaming walks the map downward in MSB-first order.
							s_nxt.addr = lsb ? s_r.addr + 8'h01 : s_r.addr - 8'h01;
							s_nxt.nbytes = s_r.nbytes + 2'b01;
							if (s_r.len != sdcrm_pkg::LEN_STREAM &&
								s_r.nbytes == s_r.len)
							begin
								s_nxt.state = ST_DONE;
							end
						end
					end
				end
				ST_DONE:
				begin
					if (fall)
					begin
						s_nxt.oe = 1'b0;
					end
				end
				default:
				begin
					s_nxt.state = ST_INSTR;
				end
			endcase
		end
		if (rst_i)
		begin
			s_nxt = '0;
			s_nxt.csb_sy = 2'b11;
			s_nxt.sclk_sy = 2'b00;
			s_nxt.state = ST_INSTR;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		s_r <= s_nxt;
	end

	assign sdio_o = s_r.dout;
	assign sdio_oe_o = s_r.oe;
	assign bus.wr_en = s_r.wr_en;
	assign bus.wr_addr = s_r.wr_addr;
	assign bus.wdata = s_r.wdata;
	assign bus.rd_addr = s_r.addr;

endmodule : sdcrm_serial

//--- hw/sdcrm_top.sv
// Shadowed dual-channel register bank behind a three-wire serial port.
//
// Behaviour
// - Writes to shadowed addresses are stored but do not act until transfer.
// - Writing 0x01 to 0xFF copies all pending shadow values at once.
// - The transfer bit clears itself after the update.
// - Local registers have one copy per channel, chosen by 0x05.
// - With both channel bits set, a local write updates both copies.
// - With both channel bits set, a local read returns channel A.
// - Global registers ignore the channel select setting.
// - Reset loads every register with its default.
// - The output format register at 0x14 resets to 0x05.
// - Each address holds one byte with bit 7 as MSB.
// - Supported groups: 0x00-0x02, 0x05 and 0xFF, 0x08-0x25 except 0x13, 0x3A-0x59.
// - A frame is a 16-bit instruction then bytes counted by two bits.
// - The port shifts MSB first unless configured for LSB first.
`timescale 1ns/1ps
module sdcrm_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic sclk_i,
	input wire logic csb_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	// Active configuration
	output logic [7:0] out_fmt_a_o,
	output logic [7:0] out_fmt_b_o,
	output logic [1:0] chan_sel_o,
	output logic xfer_pending_o
);

	// ****************************************
	// Address classes
	// ****************************************
	function automatic logic sdcrm_supported(input logic [7:0] a);
		return (a <= sdcrm_pkg::ADDR_CHIP_LAST) ||
			(a == sdcrm_pkg::ADDR_CHAN_SEL) || (a == sdcrm_pkg::ADDR_XFER) ||
			(a >= sdcrm_pkg::ADDR_FUNC_FIRST && a <= sdcrm_pkg::ADDR_FUNC_LAST &&
			a != sdcrm_pkg::ADDR_OPEN_HOLE) ||
			(a >= sdcrm_pkg::ADDR_DIG_FIRST && a <= sdcrm_pkg::ADDR_DIG_LAST);
	endfunction : sdcrm_supported

	function automatic logic sdcrm_shadowed(input logic [7:0] a);
		return (a >= sdcrm_pkg::ADDR_FUNC_FIRST &&
			a <= sdcrm_pkg::ADDR_SHADOW_LO_LAST) ||
			(a >= sdcrm_pkg::ADDR_DIG_FIRST && a <= sdcrm_pkg::ADDR_DIG_LAST);
	endfunction : sdcrm_shadowed

	function automatic logic sdcrm_local(input logic [7:0] a);
		return a >= sdcrm_pkg::ADDR_LOCAL_FIRST &&
			a <= sdcrm_pkg::ADDR_LOCAL_LAST;
	endfunction : sdcrm_local

	function automatic logic [7:0] sdcrm_default(input logic [7:0] a);
		logic [7:0] v;
		v = sdcrm_pkg::RST_OTHER;
		if (a == sdcrm_pkg::ADDR_OUT_FMT)
		begin
			v = sdcrm_pkg::RST_OUT_FMT;
		end
		else if (a == sdcrm_pkg::ADDR_CHAN_SEL)
		begin
			v = sdcrm_pkg::RST_CHAN_SEL;
		end
		else if (a == sdcrm_pkg::ADDR_PORT_CFG)
		begin
			v = sdcrm_pkg::RST_PORT_CFG;
		end
		return v;
	endfunction : sdcrm_default

	// ****************************************
	// State
	// ****************************************
	// Global registers live in copy 0 only; copy 1 of a global is never used.
	typedef struct packed {
		logic [1:0][255:0][7:0] shadow;
		logic [1:0][255:0][7:0] active;
		logic xfer;
	} sdcrm_bank_t;

	sdcrm_bank_t s_r;
	sdcrm_bank_t s_nxt;

	sdcrm_bus_if bus ();

	sdcrm_serial u_serial (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.sclk_i(sclk_i),
		.csb_n_i(csb_n_i),
		.sdio_i(sdio_i),
		.sdio_o(sdio_o),
		.sdio_oe_o(sdio_oe_o),
		.bus(bus)
	);

	logic [7:0] chan_sel;
	assign chan_sel = s_r.shadow[0][sdcrm_pkg::ADDR_CHAN_SEL];

	// ****************************************
	// Register update
	// ****************************************
	always_comb
	begin
		logic [7:0] wa;
		wa = bus.wr_addr;
		s_nxt = s_r;
		if (s_r.xfer)
		begin
			// All shadowed bytes move in the same cycle.
			for (int ch = 0; ch < 2; ch++)
			begin
				for (int a = 0; a < 256; a++)
				begin
					if (sdcrm_shadowed(8'(a)))
					begin
						s_nxt.active[ch][a] = s_r.shadow[ch][a];
					end
				end
			end
			s_nxt.xfer = 1'b0;
		end
		// A new transfer command in the clearing cycle wins over the clear.
		if (bus.wr_en && sdcrm_supported(wa))
		begin
			if (wa == sdcrm_pkg::ADDR_XFER)
			begin
				if (bus.wdata == sdcrm_pkg::XFER_CMD)
				begin
					s_nxt.xfer = 1'b1;
				end
			end
			else if (sdcrm_local(wa))
			begin
				for (int ch = 0; ch < 2; ch++)
				begin
					if (chan_sel[ch])
					begin
						s_nxt.shadow[ch][wa] = bus.wdata;
						if (!sdcrm_shadowed(wa))
						begin
							s_nxt.active[ch][wa] = bus.wdata;
						end
					end
				end
			end
			else
			begin
				s_nxt.shadow[0][wa] = bus.wdata;
				if (!sdcrm_shadowed(wa))
				begin
					s_nxt.active[0][wa] = bus.wdata;
				end
			end
		end
		if (rst_i)
		begin
			for (int ch = 0; ch < 2; ch++)
			begin
				for (int a = 0; a < 256; a++)
				begin
					s_nxt.shadow[ch][a] = sdcrm_default(8'(a));
					s_nxt.active[ch][a] = sdcrm_default(8'(a));
				end
			end
			s_nxt.xfer = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		s_r <= s_nxt;
	end

	// ****************************************
	// Read path
	// ****************************************
	// Reads show the written (shadow) value, so software can verify a
	// pending write before it issues the transfer.
	always_comb
	begin
		logic [7:0] ra;
		logic ch_b;
		ra = bus.rd_addr;
		// Channel B only when A is clear and B set.
		ch_b = sdcrm_local(ra) && !chan_sel[sdcrm_pkg::BIT_CHAN_A] &&
			chan_sel[sdcrm_pkg::BIT_CHAN_B];
		if (!sdcrm_supported(ra))
		begin
			bus.rdata = 8'h00;
		end
		else if (ra == sdcrm_pkg::ADDR_XFER)
		begin
			bus.rdata = {7'h00, s_r.xfer};
		end
		else
		begin
			bus.rdata = s_r.shadow[ch_b][ra];
		end
	end

	assign bus.lsb_first =
		s_r.shadow[0][sdcrm_pkg::ADDR_PORT_CFG][sdcrm_pkg::BIT_LSB_FIRST];

	// ****************************************
	// Outputs
	// ****************************************
	assign out_fmt_a_o = s_r.active[0][sdcrm_pkg::ADDR_OUT_FMT];
	assign out_fmt_b_o = s_r.active[1][sdcrm_pkg::ADDR_OUT_FMT];
	assign chan_sel_o = s_r.shadow[0][sdcrm_pkg::ADDR_CHAN_SEL][1:0];
	assign xfer_pending_o = s_r.xfer;

endmodule : sdcrm_top

//--- sim/sdcrm_properties.sv
// Concurrent checks on the pins of the shadowed register bank.
`timescale 1ns/1ps
module sdcrm_properties (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic sclk_i,
	input wire logic csb_n_i,
	input wire logic sdio_i,
	input wire logic sdio_o,
	input wire logic sdio_oe_o,
	// Active configuration
	input wire logic [7:0] out_fmt_a_o,
	input wire logic [7:0] out_fmt_b_o,
	input wire logic [1:0] chan_sel_o,
	input wire logic xfer_pending_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_reset_defaults: assert property (
		disable iff (1'b0) rst_i |=> out_fmt_a_o == 8'h05 &&
		out_fmt_b_o == 8'h05 && chan_sel_o == 2'b11 &&
		!xfer_pending_o && !sdio_oe_o)
		else $error("reset values wrong");
	a_xfer_one_pulse: assert property (
		xfer_pending_o |=> !xfer_pending_o)
		else $error("transfer bit did not clear");
	a_fmt_held_shadow: assert property (
		!$stable({out_fmt_a_o, out_fmt_b_o}) |-> $past(xfer_pending_o))
		else $error("active format changed without transfer");
	a_xfer_in_frame: assert property (
		xfer_pending_o |-> !$past(csb_n_i, 4))
		else $error("transfer outside a frame");
	a_sel_in_frame: assert property (
		!$stable(chan_sel_o) |-> !$past(csb_n_i, 4))
		else $error("channel select changed outside a frame");
	a_oe_idle_off: assert property (
		csb_n_i [*6] |-> !sdio_oe_o)
		else $error("pin driven while deselected");
	a_oe_after_fall: assert property (
		$rose(sdio_oe_o) |-> !$past(csb_n_i, 2) && !$past(sclk_i, 2))
		else $error("drive began off a falling edge");
	a_data_holds_high: assert property (
		$rose(sclk_i) |-> ##1 $stable(sdio_o) [*3])
		else $error("read data moved while clock high");
endmodule : sdcrm_properties

bind sdcrm_top sdcrm_properties u_sdcrm_properties (
	.clk_sys_i(clk_sys_i),
	.rst_i(rst_i),
	.sclk_i(sclk_i),
	.csb_n_i(csb_n_i),
	.sdio_i(sdio_i),
	.sdio_o(sdio_o),
	.sdio_oe_o(sdio_oe_o),
	.out_fmt_a_o(out_fmt_a_o),
	.out_fmt_b_o(out_fmt_b_o),
	.chan_sel_o(chan_sel_o),
	.xfer_pending_o(xfer_pending_o)
);

//--- sim/sdcrm_host_model.sv
// Serial host model that frames single-byte reads and short writes.
`timescale 1ns/1ps
module sdcrm_host_model (
	// Clock
	input wire logic clk_sys_i,
	// Serial pins
	output logic sclk_o,
	output logic csb_n_o,
	output logic sdio_o,
	input wire logic sdio_i,
	// Read results
	output logic rd_done_o,
	output logic [7:0] rd_data_o
);
	logic lsb;

	initial
	begin
		sclk_o = 1'b0;
		csb_n_o = 1'b1;
		sdio_o = 1'b0;
		rd_done_o = 1'b0;
		rd_data_o = 8'h00;
		lsb = 1'b0;
	end

	// The clock idles low and the released line toggles, so nothing stale
	// can pass for read data.
	// The first data byte sits in wd[15:8], a second one in wd[7:0].
	task automatic frame(input logic rd, input logic [1:0] len,
		input logic [7:0] addr, input logic [15:0] wd);
		logic [31:0] w;
		logic [7:0] rv;
		int b;
		int p;
		int n;
		w = {rd, len, 5'h00, addr, wd};
		rv = 8'h00;
		n = 24 + 8 * int'(len);
		@(posedge clk_sys_i);
		csb_n_o <= 1'b0;
		for (int k = 0; k < n; k++)
		begin
			p = k % 8;
			if (k < 16)
				b = 16 + (lsb ? k : 15 - k);
			else
				b = ((k < 24) ? 8 : 0) + (lsb ? p : 7 - p);
			repeat (2) @(posedge clk_sys_i);
			sdio_o <= (k < 16 || !rd) ? w[b] : ~sdio_o;
			repeat (5) @(posedge clk_sys_i);
			sclk_o <= 1'b1;
			if (k >= 16 && k < 24)
				rv[b - 8] = sdio_i;
			repeat (4) @(posedge clk_sys_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge clk_sys_i);
		csb_n_o <= 1'b1;
		sdio_o <= ~sdio_o;
		rd_data_o <= rv;
		rd_done_o <= rd;
		@(posedge clk_sys_i);
		rd_done_o <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
	endtask : frame
endmodule : sdcrm_host_model

//--- sim/tb_top.sv
// Self-checking bench for the shadowed dual-channel register bank.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk, csb_n, host_sdio, sdio, dut_sdio, sdio_oe, xfer, rd_done;
	logic [7:0] fmt_a, fmt_b, rd_data, d1, d2;
	logic [1:0] chan_sel;
	logic [7:0] exp_q[$];
	int seed = 48659;
	int bad_count = 0;
	int n_checks = 0;
	int xfer_seen = 0;

	assign sdio = sdio_oe ? dut_sdio : host_sdio;

	initial
	begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	sdcrm_top u_sdcrm_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.sclk_i(sclk), .csb_n_i(csb_n), .sdio_i(sdio), .sdio_o(dut_sdio),
		.sdio_oe_o(sdio_oe), .out_fmt_a_o(fmt_a), .out_fmt_b_o(fmt_b),
		.chan_sel_o(chan_sel), .xfer_pending_o(xfer));

	sdcrm_host_model u_sdcrm_host_model (.clk_sys_i(clk_sys_i),
		.sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(host_sdio), .sdio_i(sdio),
		.rd_done_o(rd_done), .rd_data_o(rd_data));

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_sdcrm_host_model.frame(1'b0, 2'b00, a, {d, 8'h00});
	endtask : wr

	task automatic wr2(input logic [7:0] a, input logic [7:0] b0,
		input logic [7:0] b1);
		u_sdcrm_host_model.frame(1'b0, 2'b01, a, {b0, b1});
	endtask : wr2

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_sdcrm_host_model.frame(1'b1, 2'b00, a, 16'h0000);
	endtask : rd

	task automatic test_done();
		$display("checks=%0d errors=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	always @(posedge clk_sys_i)
		if (rd_done === 1'b1)
			cmp8(rd_data, exp_q.pop_front());

	// Counts the cycles in which the transfer bit stands high.
	always @(posedge clk_sys_i)
		if (xfer === 1'b1)
			xfer_seen++;

	// A hang is cut off well beyond the expected run of about 8500 cycles.
	initial
	begin
		repeat (40000) @(posedge clk_sys_i);
		bad_count++;
		test_done();
	end

	initial
	begin
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		cmp8(fmt_a, 8'h05);
		cmp8(fmt_b, 8'h05);
		cmp8({4'h0, sdio_oe, xfer, chan_sel}, 8'h03);
		rd(8'h14, 8'h05);
		rd(8'h05, 8'h03);
		// Fixed bits keep d1, d2 and ~d1 distinct, and d1 and d2 apart from the reset value.
		d1 = 8'($random(seed)) | 8'hc0;
		d2 = (8'($random(seed)) & 8'h7f) | 8'h40;
		wr(8'h14, d1);
		cmp8(fmt_a, 8'h05);
		rd(8'h14, d1);
		wr(8'h05, 8'h02);
		wr(8'h14, d2);
		rd(8'h14, d2);
		wr(8'h05, 8'h01);
		rd(8'h14, d1);
		wr(8'hff, 8'h01);
		cmp8(fmt_a, d1);
		cmp8(fmt_b, d2);
		cmp8(8'(xfer_seen), 8'h01);
		rd(8'hff, 8'h00);
		wr(8'h05, 8'h03);
		wr(8'h14, ~d1);
		wr(8'hff, 8'h03);
		cmp8(fmt_b, d2);
		cmp8(8'(xfer_seen), 8'h01);
		wr(8'hff, 8'h01);
		cmp8(fmt_a, ~d1);
		cmp8(fmt_b, ~d1);
		cmp8(8'(xfer_seen), 8'h02);
		wr(8'h05, 8'h01);
		wr(8'h3a, d2);
		wr(8'h05, 8'h02);
		rd(8'h3a, d2);
		wr(8'h30, 8'h5a);
		rd(8'h30, 8'h00);
		rd(8'h13, 8'h00);
		wr(8'h00, 8'h40);
		u_sdcrm_host_model.lsb = 1'b1;
		rd(8'h14, ~d1);
		wr(8'h00, 8'h00);
		u_sdcrm_host_model.lsb = 1'b0;
		rd(8'h00, 8'h00);
		// Two bytes in one frame land at the address and the one below it.
		wr2(8'h15, d2, d1);
		rd(8'h15, d2);
		rd(8'h14, d1);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		cmp8(fmt_b, 8'h05);
		rd(8'h14, 8'h05);
		repeat (4) @(posedge clk_sys_i);
		test_done();
	end
endmodule : tb_top
